// ---- hdl/pin_mux_pkg.sv ----
// Summary of operation
// - Pin function from reset straps plus software
// - Apply software selection unchecked, never reject
// - All options except memory width set through selection registers
// - First register video in, second video out
// - Third memory, fourth gpio, fifth serial/card
// - Strap pins revert to memory after sampling
// - Boot config sets default address pins and memory width
// - Software rewrites address pin count any time after strap capture
// - Video in: gpio, video, fourth serial
// - Video out: gpio, video, pwm/real-time
// - Memory pins: memory, gpio; tertiary reads as memory
// - Serial port pins: gpio, serial port
// - Second card: gpio, card, external memory
// - Ethernet: gpio, interrupt input, ethernet
// - Config top bit: 0 8-bit, 1 16-bit
// - Unassigned address pins become gpio after capture
package pin_mux_pkg;
   // ****************************************
   // Select encodings
   // ****************************************
   localparam logic [1:0] SEL_PRIMARY = 2'h0;
   localparam logic [1:0] SEL_SECONDARY = 2'h1;
   localparam logic [1:0] SEL_TERTIARY = 2'h2;
   typedef enum logic [1:0] {FUNC_A, FUNC_B, FUNC_C} func_type;
   // ****************************************
   // Widths and field positions
   // ****************************************
   localparam int REG_W = 32;
   localparam int CFG_W = 3;
   localparam int CFG_WIDE_BIT = 2;
   localparam int ADDR_PINS = 23;
   localparam int ADDR_CNT_W = 5;
   localparam int ADDR_CNT_LSB = 0;
   localparam int ADDR_OVR_BIT = 8;
   localparam int MEM_SEL_LSB = 0;
   localparam int SER_SEL_LSB = 2;
   localparam int CARD_SEL_LSB = 4;
   localparam int ETH_SEL_LSB = 0;
   localparam int VID_SEL_LSB = 0;
   localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;
   localparam logic [ADDR_CNT_W-1:0] BASE_ADDR_8 = 5'h02;
   localparam logic [ADDR_CNT_W-1:0] BASE_ADDR_16 = 5'h01;
   localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage

// ---- hdl/sel_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sel_if;
   logic [1:0] sel;
   pin_mux_pkg::func_type func;
   modport ctl (output sel, input func);
   modport dec (input sel, output func);
endinterface
`default_nettype wire

// ---- hdl/func_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module func_decode (
   sel_if.dec s
);
   always_comb begin
      case (s.sel)
         pin_mux_pkg::SEL_SECONDARY: s.func = pin_mux_pkg::FUNC_B;
         pin_mux_pkg::SEL_TERTIARY: s.func = pin_mux_pkg::FUNC_C;
         default: s.func = pin_mux_pkg::FUNC_A; // Undefined falls back
      endcase
   end
endmodule
`default_nettype wire

// ---- hdl/peripheral_pin_multiplexer.sv ----
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_multiplexer #(
   parameter int NPIN = 23
) (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic [pin_mux_pkg::REG_W-1:0] VIDEO_IN_SELECT_REG,
   input wire logic [pin_mux_pkg::REG_W-1:0] VIDEO_OUT_SELECT_REG,
   input wire logic [pin_mux_pkg::REG_W-1:0] ASYNC_MEM_SELECT_REG,
   input wire logic [pin_mux_pkg::REG_W-1:0] GPIO_SELECT_REG,
   input wire logic [pin_mux_pkg::REG_W-1:0] SERIAL_CARD_SELECT_REG,
   input wire logic [pin_mux_pkg::CFG_W-1:0] ASYNC_MEM_BOOT_CONFIG,
   output logic [1:0] VIDEO_IN_FUNC,
   output logic [1:0] VIDEO_OUT_FUNC,
   output logic [1:0] MEM_FUNC,
   output logic [1:0] SERIAL_PORT_FUNC,
   output logic [1:0] SECOND_CARD_FUNC,
   output logic [1:0] ETHERNET_FUNC,
   output logic [NPIN-1:0] ADDR_PIN_ENABLE,
   output logic [NPIN-1:0] ADDR_PIN_GPIO,
   output logic STRAP_PHASE,
   output logic MEM_WIDE
);
   // ****************************************
   // Strap capture
   // ****************************************
   // Straps cross from pins: two stages before use
   logic [pin_mux_pkg::CFG_W-1:0] sync1_q, sync2_q, cfg_q, cfg_d;
   logic sampled_q, sampled_d;
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= ASYNC_MEM_BOOT_CONFIG;
         sync2_q <= sync1_q;
      end
   end
   // Capture once after release, then the pins serve memory
   logic [1:0] wait_q, wait_d;
   always_comb begin
      wait_d = wait_q;
      sampled_d = sampled_q;
      cfg_d = cfg_q;
      if (!sampled_q) begin
         if (wait_q == pin_mux_pkg::STRAP_WAIT) begin
            sampled_d = 1'b1;
            cfg_d = sync2_q;
         end else begin
            wait_d = wait_q + 2'h1;
         end
      end
   end
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         wait_q <= 2'h0;
         sampled_q <= 1'b0;
         cfg_q <= '0;
      end else begin
         wait_q <= wait_d;
         sampled_q <= sampled_d;
         cfg_q <= cfg_d;
      end
   end
   // ****************************************
   // Function decode per group
   // ****************************************
   // Selections are applied as written; no cross-checking
   localparam int NG = 6;
   logic [1:0] sel_v [NG];
   logic [1:0] func_v [NG];
   assign sel_v[0] = VIDEO_IN_SELECT_REG[pin_mux_pkg::VID_SEL_LSB +: 2];
   assign sel_v[1] = VIDEO_OUT_SELECT_REG[pin_mux_pkg::VID_SEL_LSB +: 2];
   // Memory group has no tertiary: treat it as primary
   assign sel_v[2] = (ASYNC_MEM_SELECT_REG[pin_mux_pkg::MEM_SEL_LSB +: 2]
                      == pin_mux_pkg::SEL_TERTIARY) ? pin_mux_pkg::SEL_PRIMARY
                      : ASYNC_MEM_SELECT_REG[pin_mux_pkg::MEM_SEL_LSB +: 2];
   // Serial port has no tertiary
   assign sel_v[3] = (GPIO_SELECT_REG[pin_mux_pkg::SER_SEL_LSB +: 2]
                      == pin_mux_pkg::SEL_TERTIARY) ? pin_mux_pkg::SEL_PRIMARY
                      : GPIO_SELECT_REG[pin_mux_pkg::SER_SEL_LSB +: 2];
   assign sel_v[4] = SERIAL_CARD_SELECT_REG[pin_mux_pkg::CARD_SEL_LSB +: 2];
   assign sel_v[5] = GPIO_SELECT_REG[pin_mux_pkg::ETH_SEL_LSB +: 2];
   genvar g;
   generate
      for (g = 0; g < NG; g++) begin : grp
         sel_if s ();
         assign s.sel = sel_v[g];
         func_decode u_dec (.s(s));
         assign func_v[g] = 2'(s.func);
      end
   endgenerate
   // ****************************************
   // Address pin count
   // ****************************************
   // Override bit lets software grow or shrink the count at any time once straps are captured
   logic [pin_mux_pkg::ADDR_CNT_W-1:0] cnt;
   logic [pin_mux_pkg::ADDR_CNT_W-1:0] base_cnt;
   always_comb begin
      // Address pin count and memory width come from the strap
      base_cnt = cfg_q[pin_mux_pkg::CFG_WIDE_BIT] ? pin_mux_pkg::BASE_ADDR_16
                 : pin_mux_pkg::BASE_ADDR_8;
      if (ASYNC_MEM_SELECT_REG[pin_mux_pkg::ADDR_OVR_BIT]) begin
         cnt = ASYNC_MEM_SELECT_REG[pin_mux_pkg::ADDR_CNT_LSB +: pin_mux_pkg::ADDR_CNT_W];
      end else begin
         cnt = base_cnt + {cfg_q[pin_mux_pkg::CFG_WIDE_BIT-1:0], 1'b0};
      end
   end
   // ****************************************
   // Output registers
   // ****************************************
   logic [1:0] vin_func_q, vin_func_d;
   logic [1:0] vout_func_q, vout_func_d;
   logic [1:0] mem_func_q, mem_func_d;
   logic [1:0] ser_func_q, ser_func_d;
   logic [1:0] card_func_q, card_func_d;
   logic [1:0] eth_func_q, eth_func_d;
   logic [NPIN-1:0] en_q, en_d;
   logic [NPIN-1:0] gpio_q, gpio_d;
   logic phase_q, phase_d;
   logic wide_q, wide_d;
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         en_d[i] = (i < int'(cnt)) && sampled_q;
      end
      vin_func_d = func_v[0];
      vout_func_d = func_v[1];
      // Strap pins stay memory pins while being sampled
      mem_func_d = sampled_q ? func_v[2] : pin_mux_pkg::SEL_PRIMARY;
      ser_func_d = func_v[3];
      card_func_d = func_v[4];
      eth_func_d = func_v[5];
      // No pin handed to gpio before capture
      gpio_d = sampled_q ? ~en_d : '0;
      phase_d = !sampled_q;
      wide_d = cfg_q[pin_mux_pkg::CFG_WIDE_BIT];
   end
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         vin_func_q <= pin_mux_pkg::SEL_PRIMARY;
         vout_func_q <= pin_mux_pkg::SEL_PRIMARY;
         mem_func_q <= pin_mux_pkg::SEL_PRIMARY;
         ser_func_q <= pin_mux_pkg::SEL_PRIMARY;
         card_func_q <= pin_mux_pkg::SEL_PRIMARY;
         eth_func_q <= pin_mux_pkg::SEL_PRIMARY;
         en_q <= '0;
         gpio_q <= '0;
         phase_q <= 1'b1;
         wide_q <= 1'b0;
      end else begin
         vin_func_q <= vin_func_d;
         vout_func_q <= vout_func_d;
         mem_func_q <= mem_func_d;
         ser_func_q <= ser_func_d;
         card_func_q <= card_func_d;
         eth_func_q <= eth_func_d;
         en_q <= en_d;
         gpio_q <= gpio_d;
         phase_q <= phase_d;
         wide_q <= wide_d;
      end
   end
   assign VIDEO_IN_FUNC = vin_func_q;
   assign VIDEO_OUT_FUNC = vout_func_q;
   assign MEM_FUNC = mem_func_q;
   assign SERIAL_PORT_FUNC = ser_func_q;
   assign SECOND_CARD_FUNC = card_func_q;
   assign ETHERNET_FUNC = eth_func_q;
   assign ADDR_PIN_ENABLE = en_q;
   assign ADDR_PIN_GPIO = gpio_q;
   assign STRAP_PHASE = phase_q;
   assign MEM_WIDE = wide_q;
endmodule
`default_nettype wire

// ---- bench/pin_mux_board.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// Strap drivers
// ********
module pin_mux_board (
   input wire logic [2:0] STRAP,
   input wire logic DRIVE,
   output logic [2:0] PINS
);
   // Released pins fall to pull-down, never the old strap
   assign PINS = DRIVE ? STRAP : 3'h0;
endmodule
`default_nettype wire

// ---- bench/peripheral_pin_multiplexer_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_multiplexer_chk #(parameter int NPIN = 23) (
   input wire logic CLOCK, RESET_N, STRAP_PHASE, MEM_WIDE,
   input wire logic [31:0] VIDEO_IN_SELECT_REG, VIDEO_OUT_SELECT_REG, ASYNC_MEM_SELECT_REG,
   input wire logic [31:0] GPIO_SELECT_REG, SERIAL_CARD_SELECT_REG,
   input wire logic [2:0] ASYNC_MEM_BOOT_CONFIG,
   input wire logic [1:0] VIDEO_IN_FUNC, VIDEO_OUT_FUNC, MEM_FUNC, SERIAL_PORT_FUNC,
   input wire logic [1:0] SECOND_CARD_FUNC, ETHERNET_FUNC,
   input wire logic [NPIN-1:0] ADDR_PIN_ENABLE, ADDR_PIN_GPIO
);
   // ********
   // Checks
   // ********
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   function automatic logic [1:0] m3(logic [1:0] s); return (s == 2'h3) ? 2'h0 : s; endfunction
   function automatic logic [1:0] m2(logic [1:0] s); return s[1] ? 2'h0 : s; endfunction
   // Shift past the width leaves all pins enabled
   function automatic logic [NPIN-1:0] msk(logic [4:0] n); return ~({NPIN{1'b1}} << n); endfunction
   sequence s_set; !STRAP_PHASE ##1 !STRAP_PHASE; endsequence
   property p_vin;
      $past(RESET_N) |-> VIDEO_IN_FUNC == m3($past(VIDEO_IN_SELECT_REG[1:0])); endproperty
   a_vin: assert property (p_vin) else $error("video in select wrong");
   property p_vout;
      $past(RESET_N) |-> VIDEO_OUT_FUNC == m3($past(VIDEO_OUT_SELECT_REG[1:0])); endproperty
   a_vout: assert property (p_vout) else $error("video out select wrong");
   property p_card;
      $past(RESET_N) |-> SECOND_CARD_FUNC == m3($past(SERIAL_CARD_SELECT_REG[5:4])); endproperty
   a_card: assert property (p_card) else $error("card select wrong");
   property p_eth;
      $past(RESET_N) |-> ETHERNET_FUNC == m3($past(GPIO_SELECT_REG[1:0])); endproperty
   a_eth: assert property (p_eth) else $error("ethernet select wrong");
   property p_ser;
      $past(RESET_N) |-> SERIAL_PORT_FUNC == m2($past(GPIO_SELECT_REG[3:2])); endproperty
   a_ser: assert property (p_ser) else $error("serial select wrong");
   property p_mem; s_set |-> MEM_FUNC == m2($past(ASYNC_MEM_SELECT_REG[1:0])); endproperty
   a_mem: assert property (p_mem) else $error("memory select wrong");
   property p_ovr; s_set ##0 $past(ASYNC_MEM_SELECT_REG[8]) |->
      ADDR_PIN_ENABLE == msk($past(ASYNC_MEM_SELECT_REG[4:0])); endproperty
   a_ovr: assert property (p_ovr) else $error("address override wrong");
   property p_wide; s_set ##0 !$past(ASYNC_MEM_SELECT_REG[8]) |->
      ($countones(ADDR_PIN_ENABLE) % 2) == MEM_WIDE; endproperty
   a_wide: assert property (p_wide) else $error("default count parity wrong");
   property p_keep; s_set |=> $stable(MEM_WIDE); endproperty
   a_keep: assert property (p_keep) else $error("strap changed after capture");
endmodule
`default_nettype wire

// ---- bench/peripheral_pin_multiplexer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_multiplexer_tb;
   logic CLOCK = 1'h0;
   logic RESET_N = 1'h0;
   logic [31:0] vin = 32'h0, vout = 32'h0, mem = 32'h0, gpio = 32'h0, card = 32'h0;
   logic [2:0] strap = 3'h0, cfg = 3'h0, pins;
   logic drive = 1'h1, phase, wide;
   logic [1:0] f_vin, f_vout, f_mem, f_ser, f_card, f_eth;
   logic [22:0] en, gp;
   int n_fail = 0;
   int total_checks = 0;
   always #2 CLOCK = ~CLOCK;
   pin_mux_board board_u (.STRAP(strap), .DRIVE(drive), .PINS(pins));
   peripheral_pin_multiplexer #(.NPIN(23)) dut_u (.CLOCK(CLOCK), .RESET_N(RESET_N),
      .VIDEO_IN_SELECT_REG(vin), .VIDEO_OUT_SELECT_REG(vout), .ASYNC_MEM_SELECT_REG(mem),
      .GPIO_SELECT_REG(gpio), .SERIAL_CARD_SELECT_REG(card), .ASYNC_MEM_BOOT_CONFIG(pins),
      .VIDEO_IN_FUNC(f_vin), .VIDEO_OUT_FUNC(f_vout), .MEM_FUNC(f_mem), .SERIAL_PORT_FUNC(f_ser),
      .SECOND_CARD_FUNC(f_card), .ETHERNET_FUNC(f_eth), .ADDR_PIN_ENABLE(en),
      .ADDR_PIN_GPIO(gp), .STRAP_PHASE(phase), .MEM_WIDE(wide));
   // ********
   // Model and compare
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [1:0] mf(logic [1:0] s, bit t);
      return (s == 2'h3 || (s == 2'h2 && !t)) ? 2'h0 : s;
   endfunction
   task automatic check_all;
      int n;
      logic [22:0] e;
      n = mem[8] ? int'(mem[4:0]) : (cfg[2] ? 1 : 2) + 2 * int'(cfg[1:0]);
      e = (n >= 23) ? 23'h7FFFFF : 23'((1 << n) - 1);
      chk(f_vin, mf(vin[1:0], 1));
      chk(f_vout, mf(vout[1:0], 1));
      chk(f_mem, mf(mem[1:0], 0));
      chk(f_ser, mf(gpio[3:2], 0));
      chk(f_eth, mf(gpio[1:0], 1));
      chk(f_card, mf(card[5:4], 1));
      chk(en, e);
      chk(gp, {~e});
      chk(wide, cfg[2]);
   endtask
   task automatic end_sim;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Whole run is near 476 cycles
   initial begin
      #100000;
      n_fail++;
      end_sim();
   end
   initial begin
      void'($urandom(9));
      for (int c = 0; c < 8; c++) begin
         @(negedge CLOCK);
         RESET_N = 1'h0;
         cfg = 3'(c);
         strap = 3'(c);
         drive = 1'h1;
         mem = 32'h1;
         repeat (12) @(negedge CLOCK);
         chk(phase, 1'h1);
         chk(gp, 23'h0);
         RESET_N = 1'h1;
         repeat (6) @(negedge CLOCK);
         // Pins now carry memory traffic; capture must ignore them
         drive = 1'h0;
         repeat (3) @(negedge CLOCK);
         chk(phase, 1'h0);
         check_all();
         $display("strap test %0d done", c);
      end
      for (int i = 0; i < 300; i++) begin
         vin = $urandom;
         vout = $urandom;
         mem = $urandom;
         gpio = $urandom;
         card = $urandom;
         @(negedge CLOCK);
         check_all();
      end
      $display("random select test done");
      end_sim();
   end
endmodule
bind peripheral_pin_multiplexer peripheral_pin_multiplexer_chk #(.NPIN(NPIN)) chk_u (
   .CLOCK(CLOCK), .RESET_N(RESET_N), .STRAP_PHASE(STRAP_PHASE), .MEM_WIDE(MEM_WIDE),
   .VIDEO_IN_SELECT_REG(VIDEO_IN_SELECT_REG), .VIDEO_OUT_SELECT_REG(VIDEO_OUT_SELECT_REG),
   .ASYNC_MEM_SELECT_REG(ASYNC_MEM_SELECT_REG), .GPIO_SELECT_REG(GPIO_SELECT_REG),
   .SERIAL_CARD_SELECT_REG(SERIAL_CARD_SELECT_REG), .ASYNC_MEM_BOOT_CONFIG(ASYNC_MEM_BOOT_CONFIG),
   .VIDEO_IN_FUNC(VIDEO_IN_FUNC), .VIDEO_OUT_FUNC(VIDEO_OUT_FUNC), .MEM_FUNC(MEM_FUNC),
   .SERIAL_PORT_FUNC(SERIAL_PORT_FUNC), .SECOND_CARD_FUNC(SECOND_CARD_FUNC),
   .ETHERNET_FUNC(ETHERNET_FUNC), .ADDR_PIN_ENABLE(ADDR_PIN_ENABLE), .ADDR_PIN_GPIO(ADDR_PIN_GPIO));
`default_nettype wire
